// ### rtl/wss_state_swap.sv
// world switch state swap engine between live state, guest area and host save area
// Behaviour
// - guest area starts at offset zero of page
// - every field has exactly one swap type
// - type A entry: save host, load guest
// - A/B exit: store guest, reload host value
// - B/C entry: load guest, host unsaved
// - C exit: store guest, host to default
// - exit writes every guest field at offset
// - host area same layout, based at 0x400
// - privilege byte guest only, host ignored
// - page attribute table guest only, no host
`timescale 1ns/1ps
module wss_state_swap #(
  parameter logic [wss_pkg::WSS_DATA_W-1:0] P_DR7_DEFAULT = 64'h0000_0000_0000_0000,
  parameter logic [wss_pkg::WSS_DATA_W-1:0] P_DR6_DEFAULT = 64'h0000_0000_0000_0000,
  parameter logic [wss_pkg::WSS_DATA_W-1:0] P_CR2_DEFAULT = 64'h0000_0000_0000_0000
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // world switch control
  input wire logic I_ENC_STATE_EN,
  input wire logic I_GUEST_ENTRY,
  input wire logic I_AUTOMATIC_GUEST_EXIT,
  input wire logic [wss_pkg::WSS_PFN_W-1:0] I_GSA_PAGE,
  input wire logic [wss_pkg::WSS_PFN_W-1:0] I_HOST_PAGE,
  output logic O_BUSY,
  output logic O_DONE,
  // memory port
  output wss_pkg::wss_mem_req_type O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [wss_pkg::WSS_DATA_W-1:0] I_MEM_RDATA,
  // live processor state port
  output wss_pkg::wss_state_req_type O_STATE,
  input wire logic [wss_pkg::WSS_DATA_W-1:0] I_STATE_RDATA
);
  import wss_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIELD,
    ST_CAPTURE,
    ST_MEM_WR,
    ST_MEM_RD,
    ST_STATE_WR,
    ST_NEXT
  } wss_fsm_type;

  wss_fsm_type state_r;
  logic exit_r;
  logic [WSS_IDX_W-1:0] idx_r;
  wss_field_type fld;
  logic [5:0] lane_shift;

  assign fld = wss_field(idx_r);
  assign lane_shift = {fld.off[2:0], 3'b000};

  function automatic logic [WSS_ADDR_W-1:0] unit_addr(input logic [WSS_PFN_W-1:0] page,
                                                      input logic host,
                                                      input logic [11:0] off);
    logic [11:0] page_off;
    page_off = (host ? WSS_HOST_BASE : WSS_GSA_BASE) + {off[11:3], 3'b000};
    unit_addr = {page, page_off};
  endfunction : unit_addr

  function automatic logic [WSS_DATA_W-1:0] type_c_default(input logic [WSS_IDX_W-1:0] idx);
    case (idx)
      WSS_IDX_DR7: type_c_default = P_DR7_DEFAULT;
      WSS_IDX_DR6: type_c_default = P_DR6_DEFAULT;
      default: type_c_default = P_CR2_DEFAULT;
    endcase
  endfunction : type_c_default

  // only the field's own byte lanes reach live state, reserved neighbours are dropped
  function automatic logic [WSS_DATA_W-1:0] lane_data(input logic [WSS_DATA_W-1:0] q,
                                                      input logic [7:0] be,
                                                      input logic [5:0] sh);
    logic [WSS_DATA_W-1:0] m;
    for (int i = 0; i < 8; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    lane_data = (q & m) >> sh;
  endfunction : lane_data

  // sequencer: one swap unit at a time, memory request held until acknowledged
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_r <= ST_IDLE;
      exit_r <= 1'b0;
      idx_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // requests outside encrypted-state mode are not this engine's to serve
          if (I_ENC_STATE_EN && (I_GUEST_ENTRY || I_AUTOMATIC_GUEST_EXIT)) begin
            exit_r <= I_AUTOMATIC_GUEST_EXIT && !I_GUEST_ENTRY;
            idx_r <= '0;
            state_r <= ST_FIELD;
          end
        end
        ST_FIELD: begin
          if (exit_r) begin
            state_r <= ST_CAPTURE;
          end else if (fld.kind == WSS_SWAP_A) begin
            state_r <= ST_CAPTURE;
          end else begin
            state_r <= ST_MEM_RD;
          end
        end
        ST_CAPTURE: begin
          state_r <= ST_MEM_WR;
        end
        ST_MEM_WR: begin
          if (I_MEM_ACK) begin
            if (!exit_r) begin
              state_r <= ST_MEM_RD;
            end else if (fld.kind == WSS_SWAP_A || fld.kind == WSS_SWAP_B) begin
              state_r <= ST_MEM_RD;
            end else if (fld.kind == WSS_SWAP_C) begin
              state_r <= ST_STATE_WR;
            end else begin
              state_r <= ST_NEXT;
            end
          end
        end
        ST_MEM_RD: begin
          if (I_MEM_ACK) begin
            state_r <= ST_STATE_WR;
          end
        end
        ST_STATE_WR: begin
          state_r <= ST_NEXT;
        end
        ST_NEXT: begin
          if (idx_r == WSS_LAST_IDX) begin
            state_r <= ST_IDLE;
          end else begin
            idx_r <= idx_r + 6'h01;
            state_r <= ST_FIELD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // memory request; byte enables keep neighbouring reserved bytes untouched
  // a read that chains on a write ack must win over the drop of req, or the engine stalls
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_MEM <= '0;
    end else if (state_r == ST_CAPTURE) begin
      O_MEM.req <= 1'b1;
      O_MEM.we <= 1'b1;
      O_MEM.addr <= unit_addr(exit_r ? I_GSA_PAGE : I_HOST_PAGE, !exit_r, fld.off);
      O_MEM.be <= fld.be;
      O_MEM.wdata <= I_STATE_RDATA << lane_shift;
    end else if ((state_r == ST_FIELD && !exit_r && fld.kind != WSS_SWAP_A) ||
                 (state_r == ST_MEM_WR && I_MEM_ACK && !exit_r) ||
                 (state_r == ST_MEM_WR && I_MEM_ACK && exit_r &&
                  (fld.kind == WSS_SWAP_A || fld.kind == WSS_SWAP_B))) begin
      O_MEM.req <= 1'b1;
      O_MEM.we <= 1'b0;
      O_MEM.addr <= unit_addr(exit_r ? I_HOST_PAGE : I_GSA_PAGE, exit_r, fld.off);
      O_MEM.be <= fld.be;
      O_MEM.wdata <= WSS_DATA_RST;
    end else if (O_MEM.req && I_MEM_ACK) begin
      O_MEM.req <= 1'b0;
    end
  end

  // live state port: index leads the capture by one cycle so the read settles
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_STATE <= '0;
    end else begin
      O_STATE.idx <= idx_r;
      O_STATE.we <= 1'b0;
      if (state_r == ST_MEM_RD && I_MEM_ACK) begin
        O_STATE.we <= 1'b1;
        O_STATE.wdata <= lane_data(I_MEM_RDATA, fld.be, lane_shift);
      end else if (state_r == ST_MEM_WR && I_MEM_ACK && exit_r && fld.kind == WSS_SWAP_C) begin
        O_STATE.we <= 1'b1;
        O_STATE.wdata <= type_c_default(idx_r);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= (state_r == ST_NEXT) && (idx_r == WSS_LAST_IDX);
      O_BUSY <= (state_r != ST_IDLE) && !((state_r == ST_NEXT) && (idx_r == WSS_LAST_IDX));
    end
  end

endmodule : wss_state_swap

// ### rtl/wss_pkg.sv
// shared constants, field table and carrier types of the world switch state swap block
package wss_pkg;

  localparam int WSS_DATA_W = 64;
  localparam int WSS_PFN_W = 40;
  localparam int WSS_ADDR_W = WSS_PFN_W + 12;
  localparam int WSS_IDX_W = 6;
  localparam int WSS_NUM_TYPES = 3;

  // index of the last 8-byte swap unit in the guest state area layout
  localparam logic [WSS_IDX_W-1:0] WSS_LAST_IDX = 6'h3A;

  // offsets and bases inside a save area
  localparam logic [11:0] WSS_GSA_BASE = 12'h000;
  localparam logic [11:0] WSS_HOST_BASE = 12'h400;
  localparam logic [11:0] WSS_OFF_PRIV = 12'h0CA;
  localparam logic [11:0] WSS_OFF_CPL = 12'h0CB;
  localparam logic [11:0] WSS_OFF_EFER = 12'h0D0;
  localparam logic [11:0] WSS_OFF_XSS = 12'h140;
  localparam logic [11:0] WSS_OFF_RSP = 12'h1D8;
  localparam logic [11:0] WSS_OFF_PAT = 12'h268;

  // unit index boundaries of the layout runs
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_SEG_END = 6'h13;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_SSP_END = 6'h18;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_PRIV = 6'h19;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_CPL = 6'h1A;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_EFER = 6'h1B;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_XSS = 6'h1C;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_CR0 = 6'h1F;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_DR7 = 6'h20;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_DR6 = 6'h21;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_RIP = 6'h23;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_MASK_END = 6'h2B;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_RSP = 6'h2C;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_RAX = 6'h30;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_SYS_END = 6'h38;
  localparam logic [WSS_IDX_W-1:0] WSS_IDX_CR2 = 6'h39;

  // segment swap type A mask, one bit per 16-byte segment, es at bit 0
  localparam logic [9:0] WSS_SEG_A_MASK = 10'h14F;

  // byte enables
  localparam logic [7:0] WSS_BE_QWORD = 8'hFF;
  localparam logic [7:0] WSS_BE_PRIV = 8'h04;
  localparam logic [7:0] WSS_BE_CPL = 8'h08;

  // reset values of control state
  localparam logic [WSS_DATA_W-1:0] WSS_DATA_RST = 64'h0000_0000_0000_0000;

  // guest_only: loaded from and saved to the guest area, no host action
  typedef enum logic [1:0] {
    WSS_SWAP_A,
    WSS_SWAP_B,
    WSS_SWAP_C,
    WSS_GUEST_ONLY
  } wss_kind_type;

  typedef struct packed {
    logic [11:0] off;
    logic [7:0] be;
    wss_kind_type kind;
  } wss_field_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [WSS_ADDR_W-1:0] addr;
    logic [7:0] be;
    logic [WSS_DATA_W-1:0] wdata;
  } wss_mem_req_type;

  typedef struct packed {
    logic we;
    logic [WSS_IDX_W-1:0] idx;
    logic [WSS_DATA_W-1:0] wdata;
  } wss_state_req_type;

  function automatic logic [11:0] wss_run_off(input logic [11:0] base,
                                              input logic [WSS_IDX_W-1:0] idx,
                                              input logic [WSS_IDX_W-1:0] first);
    logic [WSS_IDX_W-1:0] k;
    k = idx - first;
    wss_run_off = base + {3'b000, k, 3'b000};
  endfunction : wss_run_off

  // layout of one swap unit: every field gets exactly one kind
  function automatic wss_field_type wss_field(input logic [WSS_IDX_W-1:0] idx);
    wss_field_type f;
    f.off = wss_run_off(WSS_GSA_BASE, idx, 6'h00);
    f.be = WSS_BE_QWORD;
    f.kind = WSS_SWAP_B;
    if (idx <= WSS_IDX_SEG_END) begin
      f.kind = WSS_SEG_A_MASK[idx[4:1]] ? WSS_SWAP_A : WSS_SWAP_B;
    end else if (idx <= WSS_IDX_SSP_END) begin
      f.kind = WSS_SWAP_B;
    end else if (idx == WSS_IDX_PRIV) begin
      f.off = WSS_OFF_PRIV;
      f.be = WSS_BE_PRIV;
      f.kind = WSS_GUEST_ONLY;
    end else if (idx == WSS_IDX_CPL) begin
      f.off = WSS_OFF_CPL;
      f.be = WSS_BE_CPL;
      f.kind = WSS_SWAP_A;
    end else if (idx == WSS_IDX_EFER) begin
      f.off = WSS_OFF_EFER;
      f.kind = WSS_SWAP_A;
    end else if (idx <= WSS_IDX_MASK_END) begin
      f.off = wss_run_off(WSS_OFF_XSS, idx, WSS_IDX_XSS);
      if (idx == WSS_IDX_XSS || idx > WSS_IDX_RIP) begin
        f.kind = WSS_SWAP_B;
      end else if (idx == WSS_IDX_DR7 || idx == WSS_IDX_DR6) begin
        f.kind = WSS_SWAP_C;
      end else begin
        f.kind = WSS_SWAP_A;
      end
    end else if (idx <= WSS_IDX_CR2) begin
      f.off = wss_run_off(WSS_OFF_RSP, idx, WSS_IDX_RSP);
      if (idx <= WSS_IDX_RAX) begin
        f.kind = WSS_SWAP_A;
      end else if (idx <= WSS_IDX_SYS_END) begin
        f.kind = WSS_SWAP_B;
      end else begin
        f.kind = WSS_SWAP_C;
      end
    end else begin
      f.off = WSS_OFF_PAT;
      f.kind = WSS_GUEST_ONLY;
    end
    wss_field = f;
  endfunction : wss_field

endpackage : wss_pkg

// ### verif/wss_asserts.sv
// port checker for the world switch state swap block
`timescale 1ns/1ps
module wss_asserts (
  // clock, reset and control
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_ENC_STATE_EN,
  input wire logic I_GUEST_ENTRY,
  input wire logic I_AUTOMATIC_GUEST_EXIT,
  input wire logic [wss_pkg::WSS_PFN_W-1:0] I_GSA_PAGE,
  input wire logic [wss_pkg::WSS_PFN_W-1:0] I_HOST_PAGE,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  // memory and live state
  input wire wss_pkg::wss_mem_req_type O_MEM,
  input wire logic I_MEM_ACK,
  input wire wss_pkg::wss_state_req_type O_STATE
);
  import wss_pkg::*;
  logic exit_r;
  logic acc_r;
  logic gsa;
  logic host;
  logic rsv;
  logic [9:0] off;
  assign off = O_MEM.addr[9:0];
  assign gsa = O_MEM.addr[51:12] == I_GSA_PAGE && O_MEM.addr[11:10] == 2'b00;
  assign host = O_MEM.addr[51:12] == I_HOST_PAGE && O_MEM.addr[11:10] == 2'b01;
  // the word below and the dword above the privilege and cpl bytes are reserved too
  assign rsv = (off >= 10'h0D8 && off < 10'h140) || (off >= 10'h1C0 && off < 10'h1D8)
    || (off >= 10'h248 && off < 10'h268) || off > 10'h268
    || (off == 10'h0C8 && (O_MEM.be & 8'hF3) != 8'h00);
  // busy rises one edge after the accept, so the accept is remembered until then
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      exit_r <= 1'b0;
      acc_r <= 1'b0;
    end else if (!O_BUSY && !acc_r && I_ENC_STATE_EN &&
                 (I_GUEST_ENTRY || I_AUTOMATIC_GUEST_EXIT)) begin
      exit_r <= !I_GUEST_ENTRY;
      acc_r <= 1'b1;
    end else if (O_BUSY) begin
      acc_r <= 1'b0;
    end
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  a_area_page: assert property (O_MEM.req |-> gsa || host)
    else $error("request outside both save areas");
  a_no_reserved: assert property (O_MEM.req |-> !rsv)
    else $error("request touches a reserved range");
  a_priv_guest: assert property (O_MEM.req && off == 10'h0C8 && O_MEM.be[2] |-> gsa)
    else $error("privilege byte accessed in host area");
  a_pat_guest: assert property (O_MEM.req && off == 10'h268 |-> gsa)
    else $error("page attribute table accessed in host area");
  a_exit_host_ro: assert property (O_BUSY && exit_r && O_MEM.req && host |-> !O_MEM.we)
    else $error("host area written on exit");
  a_entry_guest_ro: assert property (O_BUSY && !exit_r && O_MEM.req && gsa |-> !O_MEM.we)
    else $error("guest area written on entry");
  a_req_held: assert property (O_MEM.req && !I_MEM_ACK |=> O_MEM.req && $stable(O_MEM))
    else $error("memory request changed before ack");
  a_done_end: assert property ($fell(O_BUSY) |-> O_DONE ##1 !O_DONE)
    else $error("busy fell without a single done pulse");
  a_off_idle: assert property (!O_BUSY && !acc_r && !I_ENC_STATE_EN |=> !O_BUSY)
    else $error("swap started while mode disabled");
endmodule : wss_asserts

bind wss_state_swap wss_asserts u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
  .I_ENC_STATE_EN(I_ENC_STATE_EN), .I_GUEST_ENTRY(I_GUEST_ENTRY),
  .I_AUTOMATIC_GUEST_EXIT(I_AUTOMATIC_GUEST_EXIT), .I_GSA_PAGE(I_GSA_PAGE),
  .I_HOST_PAGE(I_HOST_PAGE), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_MEM(O_MEM),
  .I_MEM_ACK(I_MEM_ACK), .O_STATE(O_STATE));

// ### verif/wss_mem_model.sv
// save area memory with byte lanes and a prompt or slow ack
`timescale 1ns/1ps
module wss_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire wss_pkg::wss_mem_req_type req,
  output logic ack,
  output logic [wss_pkg::WSS_DATA_W-1:0] rdata
);
  import wss_pkg::*;
  logic [63:0] mem [logic [51:0]];
  logic [1:0] cnt;
  // plain always: the bench preloads mem from its own process
  always @(posedge clk) begin
    ack <= 1'b0;
    // stale read data flips each cycle so nothing can lean on it
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 2'd0;
      rdata <= 64'h0F0F_0F0F_0F0F_0F0F;
    end else if (req.req && !ack) begin
      cnt <= cnt + 2'd1;
      if (cnt == (slow ? 2'd2 : 2'd0)) begin
        ack <= 1'b1;
        cnt <= 2'd0;
        if (req.we) begin
          for (int i = 0; i < 8; i++) begin
            if (req.be[i]) begin
              mem[req.addr][8*i +: 8] <= req.wdata[8*i +: 8];
            end
          end
        end else begin
          rdata <= mem.exists(req.addr) ? mem[req.addr] : ~{12'h000, req.addr};
        end
      end
    end
  end
endmodule : wss_mem_model

// ### verif/tb_top.sv
// self-checking bench for the world switch state swap block
`timescale 1ns/1ps
module tb_top;
  import wss_pkg::*;
  localparam logic [63:0] DR7_DEF = 64'h0000_0000_0000_0400;
  localparam logic [39:0] GPG = 40'h00_0000_0012;
  localparam logic [39:0] HPG = 40'h00_0000_0034;
  logic clk, rst, en, go_ent, go_ext, slow, busy, done, ack;
  logic [63:0] rdata, srd;
  wss_mem_req_type mreq;
  wss_state_req_type st;
  logic [63:0] live [0:63];
  int failures, comparisons;
  int uidx [8] = '{2, 8, 25, 26, 32, 44, 57, 58};
  logic [11:0] uoff [8] = '{12'h010, 12'h040, 12'h0CA, 12'h0CB, 12'h160, 12'h1D8, 12'h240,
    12'h268};
  int utyp [8] = '{0, 1, 3, 0, 2, 0, 2, 3};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  assign srd = live[st.idx];
  always @(posedge clk) begin
    if (st.we) begin
      live[st.idx] <= st.wdata;
    end
  end
  wss_state_swap #(.P_DR7_DEFAULT(DR7_DEF)) dut (.I_CLK_SYS(clk), .I_RESET(rst),
    .I_ENC_STATE_EN(en), .I_GUEST_ENTRY(go_ent), .I_AUTOMATIC_GUEST_EXIT(go_ext),
    .I_GSA_PAGE(GPG), .I_HOST_PAGE(HPG), .O_BUSY(busy), .O_DONE(done), .O_MEM(mreq),
    .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .O_STATE(st), .I_STATE_RDATA(srd));
  wss_mem_model mdl (.clk(clk), .rst(rst), .slow(slow), .req(mreq), .ack(ack), .rdata(rdata));
  function automatic logic [63:0] pat(input logic [3:0] k, input logic [11:0] o);
    pat = {4{k, o & 12'hFF8}};
  endfunction : pat
  function automatic logic [63:0] lv(input logic [3:0] k, input int u);
    lv = {k, 52'h0, 8'(u)};
  endfunction : lv
  function automatic logic [51:0] adr(input logic [39:0] pg, input logic [11:0] o);
    adr = {pg, o & 12'hFF8};
  endfunction : adr
  // byte units: lane select in memory, low byte in live state
  function automatic logic [63:0] fld(input logic [63:0] q, input int i, input bit lane);
    fld = (uidx[i] == 25 || uidx[i] == 26) ? {56'h0, q[8*(lane ? uoff[i][2:0] : 3'd0) +: 8]} : q;
  endfunction : fld
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // exit raised with entry counts as entry; a stray exit pulse mid-entry must be dropped
  task automatic run(input logic e, input logic s);
    int n;
    @(posedge clk);
    go_ent <= e;
    go_ext <= 1'b1;
    slow <= s;
    @(posedge clk);
    go_ent <= 1'b0;
    go_ext <= 1'b0;
    @(posedge clk);
    go_ext <= e;
    @(posedge clk);
    go_ext <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      failures++;
      finish_test();
    end
  endtask : run
  task automatic t_refuse();
    @(posedge clk);
    en <= 1'b0;
    go_ent <= 1'b1;
    @(posedge clk);
    go_ent <= 1'b0;
    repeat (5) begin
      @(posedge clk);
      #1;
      chk("busy while disabled", 64'h0, {63'h0, busy});
    end
    @(posedge clk);
    en <= 1'b1;
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_entry();
    logic [63:0] e;
    for (int o = 0; o < 'h270; o += 8) begin
      mdl.mem[adr(GPG, 12'(o))] = pat(4'h6, 12'(o));
      mdl.mem[adr(HPG, 12'h400 + 12'(o))] = pat(4'h7, 12'(o));
    end
    for (int u = 0; u < 64; u++) live[u] = lv(4'h1, u);
    run(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      chk("guest load", fld(pat(4'h6, uoff[i]), i, 1), fld(live[uidx[i]], i, 0));
      e = utyp[i] == 0 ? fld(lv(4'h1, uidx[i]), i, 0) : fld(pat(4'h7, uoff[i]), i, 1);
      chk("host save", e, fld(mdl.mem[adr(HPG, 12'h400 + uoff[i])], i, 1));
    end
    $display("test entry done");
  endtask : t_entry
  task automatic t_exit();
    logic [63:0] e;
    for (int u = 0; u < 64; u++) live[u] = lv(4'h2, u);
    run(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      e = fld(mdl.mem[adr(GPG, uoff[i])], i, 1);
      chk("guest store", fld(lv(4'h2, uidx[i]), i, 0), e);
      case (utyp[i])
        0: e = fld(lv(4'h1, uidx[i]), i, 0);
        1: e = fld(pat(4'h7, uoff[i]), i, 1);
        2: e = uidx[i] == 32 ? DR7_DEF : 64'h0;
        default: e = fld(lv(4'h2, uidx[i]), i, 0);
      endcase
      chk("live after exit", e, fld(live[uidx[i]], i, 0));
    end
    $display("test exit done");
  endtask : t_exit
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    en = 1'b1;
    go_ent = 1'b0;
    go_ext = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_refuse();
    t_entry();
    t_exit();
    finish_test();
  end
endmodule : tb_top
